// *** verilog/hbp_regs.svh ***
// Purpose: Register indices, field layouts, write masks and timing counts of the block.
// Assumes: Byte registers, each on one aligned 32-bit APB word (byte address = index * 4).
// Notes: Definitions only.
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH
`define HBP_IDX_DTA_LO    5'd0
`define HBP_IDX_DTA_HI    5'd1
`define HBP_IDX_DTB_LO    5'd2
`define HBP_IDX_DTB_HI    5'd3
`define HBP_IDX_DLY_LO    5'd4
`define HBP_IDX_DLY_HI    5'd5
`define HBP_IDX_DLYMX_LO  5'd6
`define HBP_IDX_DLYMX_HI  5'd7
`define HBP_IDX_CEIL_LO   5'd8
`define HBP_IDX_CEIL_HI   5'd9
`define HBP_IDX_FLOOR_LO  5'd10
`define HBP_IDX_FLOOR_HI  5'd11
`define HBP_IDX_STEP      5'd12
`define HBP_IDX_MCTL      5'd13
`define HBP_IDX_MMODE     5'd14
`define HBP_IDX_MCNT_LO   5'd15
`define HBP_IDX_MCNT_HI   5'd16
`define HBP_IDX_MCAP_LO   5'd17
`define HBP_IDX_MCAP_HI   5'd18
`define HBP_IDX_PHWIN     5'd19
`define HBP_IDX_JCTL      5'd20
`define HBP_IDX_JPRE1     5'd21
`define HBP_IDX_MSTAT     5'd25
`define HBP_NUM_CFG       25
`define HBP_NUM_REGS      26
`define HBP_MASK_FULL     8'hFF
`define HBP_MASK_HI12     8'h0F
`define HBP_MASK_HI11     8'h07
`define HBP_MASK_MCTL     8'h7F
`define HBP_MASK_MMODE    8'hF0
`define HBP_MASK_JCTL     8'h0B
`define HBP_MASK_NONE     8'h00
`define HBP_RESET_BYTE    8'h00
`define HBP_JIT_BASE_DIV  128
`define HBP_HDIV_16       6'h0F
`define HBP_HDIV_64       6'h3F
`define HBP_SDIV_4        2'h3
`endif

// *** verilog/hbp_pkg.sv ***
// Purpose: Types shared by the timing block and its bench.
// Assumes: Constants live in hbp_regs.svh.
// Notes: Structs carry the core-side inputs and the gate outputs.
package hbp_pkg;
  typedef struct packed {
    logic [11:0] period;
    logic [11:0] duty;
    logic        run;
    logic        hw_jitter;
    logic        boundary;
    logic        raw;
  } hbp_core_s;
  typedef struct packed {
    logic a_high;
    logic a_low;
    logic b_high;
    logic b_low;
  } hbp_gate_s;
  typedef enum logic [2:0] {
    HBP_SEC_T1 = 3'b000,
    HBP_SEC_T2 = 3'b001,
    HBP_SEC_T3 = 3'b010,
    HBP_SEC_T4 = 3'b011,
    HBP_SEC_T5 = 3'b100
  } hbp_section_e;
endpackage

// *** verilog/hbp_timing.sv ***
// Purpose: Dead time, pair delay, period limits, measurement counter and jitter timer.
// Assumes: clk is the PWM clock; sys, high and sub clocks arrive as same-domain tick pulses.
// Notes: The rules carried by this block follow.
`timescale 1ns/1ps
`include "hbp_regs.svh"
module hbp_timing
  import hbp_pkg::*;
#(
  parameter int INTERVAL_BASE = 8192
) (
  // Clock, enable and reset.
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Period and duty core.
  input  hbp_core_s        core,
  input  wire logic        adjust_request,
  input  wire logic [1:0]  adjust_code,
  output logic [11:0]      period_adjusted,
  output logic             adjust_shutdown,
  // Clock ticks and pins.
  input  wire logic        sys_tick,
  input  wire logic        high_tick,
  input  wire logic        sub_tick,
  input  wire logic        measure_pin,
  input  wire logic        phase_pin,
  // Results.
  output hbp_gate_s        gates,
  output logic             measure_capture_flag,
  output logic             phase_window_active,
  output logic [2:0]       jitter_section_indicator,
  output logic             jitter_timer_wrap
);
  logic [7:0]   cfg [0:`HBP_NUM_CFG-1];
  logic [7:0]   rd_val [0:`HBP_NUM_REGS-1];
  logic [4:0]   idx;
  logic         hit, wr, setup;
  logic [11:0]  act_dt_a, act_dt_b, lim_a, lim_b, off_span;
  logic [10:0]  act_delay, dl_cnt;
  logic         dl_pend, dl_tgt, b_raw;
  logic [1:0]   raw_in, raw_q, hi, lo, wait_hi, wait_lo;
  logic [11:0]  dt_cnt [0:1];
  logic [2:0]   sync1, sync2, sync3;
  logic         mpin_rise, mpin_fall, ph_rise, ph_fall;
  logic         meas_on, meas_on_q, meas_tick, cap_evt, iv_done;
  logic [1:0]   sdiv;
  logic [5:0]   hdiv;
  logic [9:0]   mcount, mcapture;
  logic [19:0]  iv_cnt, iv_end;
  logic [8:0]   win_cnt;
  logic         jt_on, jt_on_q, jt_tick, general_mode;
  logic [9:0]   jt_div, jt_mask;
  logic [7:0]   jt_cnt;
  hbp_section_e section;

  function automatic logic [7:0] wmask(input int i);
    if (i == 1 || i == 3 || i == 9 || i == 11) wmask = `HBP_MASK_HI12;
    else if (i == 5 || i == 7) wmask = `HBP_MASK_HI11;
    else if (i == `HBP_IDX_MCTL) wmask = `HBP_MASK_MCTL;
    else if (i == `HBP_IDX_MMODE) wmask = `HBP_MASK_MMODE;
    else if (i >= `HBP_IDX_MCNT_LO && i <= `HBP_IDX_MCAP_HI) wmask = `HBP_MASK_NONE;
    else if (i == `HBP_IDX_JCTL) wmask = `HBP_MASK_JCTL;
    else wmask = `HBP_MASK_FULL;
  endfunction

  // Bus decode: the answer comes in the first access cycle.
  assign idx     = paddr[6:2];
  assign hit     = (paddr[1:0] == 2'b00) && !paddr[7] && (idx < 5'(`HBP_NUM_REGS));
  assign setup   = ce && psel && !penable;
  assign pready  = ce && psel && penable;
  assign wr      = pready && pwrite && hit;

  for (genvar i = 0; i < `HBP_NUM_CFG; i++) begin : g_cfg
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cfg[i] <= `HBP_RESET_BYTE;
      end else if (wr && idx == 5'(i)) begin
        cfg[i] <= pwdata[7:0] & wmask(i);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `HBP_NUM_CFG; i++) begin
      rd_val[i] = cfg[i];
    end
    rd_val[`HBP_IDX_MCNT_LO] = mcount[7:0];
    rd_val[`HBP_IDX_MCNT_HI] = {6'h00, mcount[9:8]};
    rd_val[`HBP_IDX_MCAP_LO] = mcapture[7:0];
    rd_val[`HBP_IDX_MCAP_HI] = {6'h00, mcapture[9:8]};
    rd_val[`HBP_IDX_JCTL]    = {1'b0, section, cfg[`HBP_IDX_JCTL][3:0]};
    rd_val[`HBP_IDX_MSTAT]   = {7'h00, measure_capture_flag};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (hit && !pwrite) ? {24'h00_0000, rd_val[idx]} : 32'h0000_0000;
      pslverr <= !hit;
    end
  end

  // Shadow transfer keeps the dead-time and pair-delay values whole.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_dt_a  <= 12'h000;
      act_dt_b  <= 12'h000;
      act_delay <= 11'h000;
    end else if (ce && (core.boundary || !core.run)) begin
      act_dt_a  <= {cfg[`HBP_IDX_DTA_HI][3:0], cfg[`HBP_IDX_DTA_LO]};
      act_dt_b  <= {cfg[`HBP_IDX_DTB_HI][3:0], cfg[`HBP_IDX_DTB_LO]};
      act_delay <= {cfg[`HBP_IDX_DLY_HI][2:0], cfg[`HBP_IDX_DLY_LO]};
    end
  end

  assign off_span = core.period - core.duty;
  assign lim_a    = (act_dt_a > core.duty) ? core.duty : act_dt_a;
  assign lim_b    = (act_dt_b > off_span) ? off_span : act_dt_b;
  assign raw_in   = {b_raw, core.raw && core.run};

  // Second group: an edge of the first group is repeated after the delay; a newer edge before then replaces it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dl_cnt  <= 11'h000;
      dl_pend <= 1'b0;
      dl_tgt  <= 1'b0;
      b_raw   <= 1'b0;
    end else if (ce) begin
      if (!core.run) begin
        dl_pend <= 1'b0;
        b_raw   <= 1'b0;
      end else if (raw_in[0] != raw_q[0]) begin
        dl_cnt  <= 11'h001;
        dl_pend <= (act_delay != 11'h000);
        dl_tgt  <= raw_in[0];
        if (act_delay == 11'h000) begin
          b_raw <= raw_in[0];
        end
      end else if (dl_pend) begin
        if (dl_cnt >= act_delay) begin
          b_raw   <= dl_tgt;
          dl_pend <= 1'b0;
        end else begin
          dl_cnt <= dl_cnt + 11'h001;
        end
      end
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_pair
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        raw_q[p]   <= 1'b0;
        hi[p]      <= 1'b0;
        lo[p]      <= 1'b0;
        wait_hi[p] <= 1'b0;
        wait_lo[p] <= 1'b0;
        dt_cnt[p]  <= 12'h000;
      end else if (ce) begin
        raw_q[p] <= raw_in[p];
        if (!core.run) begin
          hi[p]      <= 1'b0;
          lo[p]      <= 1'b0;
          wait_hi[p] <= 1'b0;
          wait_lo[p] <= 1'b0;
        end else if (raw_in[p] && !raw_q[p]) begin
          lo[p]      <= 1'b0;
          dt_cnt[p]  <= 12'h000;
          wait_hi[p] <= 1'b1;
          wait_lo[p] <= 1'b0;
        end else if (!raw_in[p] && raw_q[p]) begin
          hi[p]      <= 1'b0;
          dt_cnt[p]  <= 12'h000;
          wait_lo[p] <= 1'b1;
          wait_hi[p] <= 1'b0;
        end else if (wait_hi[p]) begin
          if (dt_cnt[p] >= lim_a) begin
            hi[p]      <= 1'b1;
            wait_hi[p] <= 1'b0;
          end else begin
            dt_cnt[p] <= dt_cnt[p] + 12'h001;
          end
        end else if (wait_lo[p]) begin
          if (dt_cnt[p] >= lim_b) begin
            lo[p]      <= 1'b1;
            wait_lo[p] <= 1'b0;
          end else begin
            dt_cnt[p] <= dt_cnt[p] + 12'h001;
          end
        end
      end
    end
  end
  assign gates = '{a_high: hi[0], a_low: lo[0], b_high: hi[1], b_low: lo[1]};

  // Period step-down under protection adjust codes 10 and 11.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_adjusted <= 12'h000;
      adjust_shutdown <= 1'b0;
    end else if (ce) begin
      if (!adjust_request || !adjust_code[1] || !core.run) begin
        period_adjusted <= core.period;
        adjust_shutdown <= 1'b0;
      end else if (core.boundary) begin
        if (period_adjusted < {cfg[`HBP_IDX_FLOOR_HI][3:0], cfg[`HBP_IDX_FLOOR_LO]}) begin
          adjust_shutdown <= !adjust_code[0];
        end else begin
          period_adjusted <= period_adjusted - {4'h0, cfg[`HBP_IDX_STEP]};
        end
      end
    end
  end

  // Pin synchronisers: bit 0 measure pin, bit 1 phase pin.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else if (ce) begin
      sync1 <= {1'b0, phase_pin, measure_pin};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign mpin_rise = sync2[0] && !sync3[0];
  assign mpin_fall = !sync2[0] && sync3[0];
  assign ph_rise   = sync2[1] && !sync3[1];
  assign ph_fall   = !sync2[1] && sync3[1];

  assign meas_on = cfg[`HBP_IDX_MCTL][3];
  always_comb begin
    case (cfg[`HBP_IDX_MCTL][6:4])
      3'b000:  meas_tick = sys_tick && sdiv == `HBP_SDIV_4;
      3'b001:  meas_tick = sys_tick;
      3'b010:  meas_tick = high_tick && hdiv[3:0] == `HBP_HDIV_16;
      3'b011:  meas_tick = high_tick && hdiv == `HBP_HDIV_64;
      3'b110:  meas_tick = mpin_rise;
      3'b111:  meas_tick = mpin_fall;
      default: meas_tick = sub_tick;
    endcase
  end
  assign iv_end  = 20'((INTERVAL_BASE << cfg[`HBP_IDX_MCTL][2:0]) - 1);
  assign iv_done = cfg[`HBP_IDX_MMODE][7] && iv_cnt == iv_end;
  always_comb begin
    case (cfg[`HBP_IDX_MMODE][5:4])
      2'b00:   cap_evt = ph_rise;
      2'b01:   cap_evt = ph_fall;
      2'b10:   cap_evt = ph_rise || ph_fall;
      default: cap_evt = 1'b0;
    endcase
    if (cfg[`HBP_IDX_MMODE][7]) cap_evt = 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meas_on_q <= 1'b0;
      sdiv      <= 2'h0;
      hdiv      <= 6'h00;
      iv_cnt    <= 20'h0_0000;
      mcount    <= 10'h000;
      mcapture  <= 10'h000;
    end else if (ce) begin
      meas_on_q <= meas_on;
      if (meas_on && !meas_on_q) begin
        iv_cnt   <= 20'h0_0000;
        mcount   <= 10'h000;
        mcapture <= 10'h000;
      end else if (meas_on) begin
        sdiv   <= sys_tick ? sdiv + 2'h1 : sdiv;
        hdiv   <= high_tick ? hdiv + 6'h01 : hdiv;
        iv_cnt <= iv_done ? 20'h0_0000 : iv_cnt + 20'h0_0001;
        if (iv_done || cap_evt) begin
          mcapture <= mcount;
          mcount   <= 10'h000;
        end else if (meas_tick) begin
          mcount <= mcount + 10'h001;
        end
      end
    end
  end

  // Flag is cleared by writing one; a new capture in that cycle wins.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      measure_capture_flag <= 1'b0;
    end else if (ce) begin
      if (meas_on && meas_on_q && (iv_done || cap_evt)) begin
        measure_capture_flag <= 1'b1;
      end else if (wr && idx == `HBP_IDX_MSTAT && pwdata[0]) begin
        measure_capture_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt             <= 9'h000;
      phase_window_active <= 1'b0;
    end else if (ce) begin
      if (ph_rise) begin
        win_cnt             <= {1'b0, cfg[`HBP_IDX_PHWIN]};
        phase_window_active <= 1'b1;
      end else if (win_cnt != 9'h000) begin
        win_cnt <= win_cnt - 9'h001;
      end else begin
        phase_window_active <= 1'b0;
      end
    end
  end

  // Jitter timer.
  assign jt_on        = cfg[`HBP_IDX_JCTL][3];
  assign jt_mask      = 10'((`HBP_JIT_BASE_DIV << cfg[`HBP_IDX_JCTL][1:0]) - 1);
  assign jt_tick      = jt_on && high_tick && ((jt_div & jt_mask) == jt_mask);
  assign general_mode = !core.run || !core.hw_jitter;
  assign jitter_section_indicator = section;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      jt_on_q           <= 1'b0;
      jt_div            <= 10'h000;
      jt_cnt            <= 8'h00;
      section           <= HBP_SEC_T1;
      jitter_timer_wrap <= 1'b0;
    end else if (ce) begin
      jt_on_q           <= jt_on;
      jitter_timer_wrap <= 1'b0;
      if (!jt_on) begin
        jt_div <= 10'h000;
      end else if (!jt_on_q) begin
        jt_div  <= 10'h000;
        jt_cnt  <= cfg[`HBP_IDX_JPRE1];
        section <= HBP_SEC_T1;
      end else begin
        jt_div <= high_tick ? jt_div + 10'h001 : jt_div;
        if (jt_tick && section != HBP_SEC_T5) begin
          if (jt_cnt != 8'hFF) begin
            jt_cnt <= jt_cnt + 8'h01;
          end else begin
            jitter_timer_wrap <= 1'b1;
            if (general_mode || section == HBP_SEC_T4) begin
              jt_cnt  <= cfg[`HBP_IDX_JPRE1];
              section <= general_mode ? HBP_SEC_T1 : HBP_SEC_T5;
            end else begin
              jt_cnt  <= cfg[`HBP_IDX_JPRE1 + 5'(section) + 5'd1];
              section <= hbp_section_e'(section + 3'd1);
            end
          end
        end
      end
    end
  end

  property p_dt_a_wait;
    @(posedge clk) disable iff (!resetn)
    $rose(gates.a_high) |-> $past(dt_cnt[0]) >= $past(lim_a);
  endproperty
  a_dt_a_wait: assert property (p_dt_a_wait) else $error("high side rose early");
  property p_lim_a;
    @(posedge clk) disable iff (!resetn) lim_a <= core.duty;
  endproperty
  a_lim_a: assert property (p_lim_a) else $error("dead time a above duty");
  property p_lim_b;
    @(posedge clk) disable iff (!resetn) lim_b <= off_span;
  endproperty
  a_lim_b: assert property (p_lim_b) else $error("dead time b above off span");
  property p_no_overlap;
    @(posedge clk) disable iff (!resetn) !(gates.a_high && gates.a_low);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair a overlap");
  property p_meas_clear;
    @(posedge clk) disable iff (!resetn)
    ce && $rose(meas_on) |=> mcount == 10'h000 && mcapture == 10'h000;
  endproperty
  a_meas_clear: assert property (p_meas_clear) else $error("counter not cleared");
  property p_meas_hold;
    @(posedge clk) disable iff (!resetn)
    !meas_on && !meas_on_q |=> $stable(mcount) && $stable(mcapture);
  endproperty
  a_meas_hold: assert property (p_meas_hold) else $error("counter moved while off");
  property p_jt_load;
    @(posedge clk) disable iff (!resetn)
    ce && jt_on && !jt_on_q |=> jt_cnt == $past(cfg[`HBP_IDX_JPRE1]) && section == HBP_SEC_T1;
  endproperty
  a_jt_load: assert property (p_jt_load) else $error("preload not loaded");
  property p_jt_stop;
    @(posedge clk) disable iff (!resetn)
    !jt_on [*2] |-> jt_div == 10'h000 && $stable(jt_cnt);
  endproperty
  a_jt_stop: assert property (p_jt_stop) else $error("jitter timer ran while off");
  property p_window;
    @(posedge clk) disable iff (!resetn)
    ce && ph_rise && cfg[`HBP_IDX_PHWIN] == 8'h01 |=> phase_window_active [*2];
  endproperty
  a_window: assert property (p_window) else $error("phase window short");
  c_capture: cover property (@(posedge clk) disable iff (!resetn) $rose(measure_capture_flag));
  c_section: cover property (@(posedge clk) disable iff (!resetn) section == HBP_SEC_T5);
  c_gate_b:  cover property (@(posedge clk) disable iff (!resetn) $rose(gates.b_high));
  c_adjust:  cover property (@(posedge clk) disable iff (!resetn) $rose(adjust_shutdown));
endmodule

// *** bench/hbp_gate_driver_model.sv ***
// Purpose: Behavioural gate driver pair for both half-bridge legs.
// Assumes: Gate levels are active high and sampled on clk.
// Notes: Fault stays set once both switches of one leg were on together.
`timescale 1ns/1ps
module hbp_gate_driver_model
  import hbp_pkg::*;
(
  // Clock and gate levels.
  input  wire logic clk,
  input  hbp_gate_s gates,
  // Shoot-through seen.
  output logic      fault
);
  initial fault = 1'b0;
  always @(posedge clk) begin
    if ((gates.a_high && gates.a_low) || (gates.b_high && gates.b_low)) begin
      fault <= 1'b1;
    end
  end
endmodule

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the half-bridge timing block.
// Assumes: Registers at byte address index*4; interval base shortened to 16.
// Notes: Gate timings are measured edge to edge so fixed pipeline stages cancel.
`timescale 1ns/1ps
`include "hbp_regs.svh"
module tb_top
  import hbp_pkg::*;
();
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        areq = 1'b0;
  logic        st = 1'b1;
  logic        ht = 1'b1;
  logic        ph = 1'b0;
  logic [1:0]  acode = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, mflag, pwin, jwrap, adj_sd, fault;
  logic [11:0] padj;
  logic [2:0]  jsec;
  hbp_core_s   core = '0;
  hbp_gate_s   gates;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  localparam logic [7:0] MASK [25] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h07, 8'hFF,
    8'h07, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'h7F, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h0B, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  hbp_timing #(.INTERVAL_BASE(16)) hbp_timing_i (
    .clk(clk), .ce(1'b1), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core(core), .adjust_request(areq), .adjust_code(acode),
    .period_adjusted(padj), .adjust_shutdown(adj_sd), .sys_tick(st), .high_tick(ht),
    .sub_tick(1'b0), .measure_pin(1'b0), .phase_pin(ph), .gates(gates),
    .measure_capture_flag(mflag), .phase_window_active(pwin),
    .jitter_section_indicator(jsec), .jitter_timer_wrap(jwrap));

  hbp_gate_driver_model hbp_gate_driver_model_i (.clk(clk), .gates(gates), .fault(fault));

  initial begin
    forever #4 clk = ~clk;
  end

  task results();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      results();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, 8'(i * 4), d, r, e);
  endtask

  task automatic rd(input int i, output logic [31:0] r);
    logic e;
    apb(1'b0, 8'(i * 4), 8'h00, r, e);
  endtask

  task automatic wl(input int b, input logic v, output int n);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (gates[b] !== v && n < 5000);
  endtask

  task automatic ww(ref logic s, output int n);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (s !== 1'b1 && n < 5000);
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 25; i++) begin
      rd(i, r);
      chk("reset value", 0, r[7:0]);
      wr(i, 8'hFF);
      rd(i, r);
      chk("masked value", MASK[i], r[7:0]);
      wr(i, 8'h00);
    end
    apb(1'b0, 8'h68, 8'h00, r, e);
    chk("unmapped error", 1, e);
    $display("test regs done");
  endtask

  task automatic load(input logic [11:0] a, b, input logic [10:0] d, input logic [11:0] p, u);
    int n;
    wr(0, a[7:0]);
    wr(1, {4'h0, a[11:8]});
    wr(2, b[7:0]);
    wr(3, {4'h0, b[11:8]});
    wr(4, d[7:0]);
    wr(5, {5'h00, d[10:8]});
    @(posedge clk);
    core.period <= p;
    core.duty <= u;
    core.run <= 1'b1;
    core.boundary <= 1'b1;
    @(posedge clk);
    core.boundary <= 1'b0;
    wl(2, 1'b1, n);
  endtask

  task automatic t_dead(input logic [11:0] a, b, p, u, input int ea, eb);
    int n;
    load(a, b, 11'h000, p, u);
    @(posedge clk);
    core.raw <= 1'b1;
    wl(2, 1'b0, n);
    wl(3, 1'b1, n);
    chk("dead time a", ea, n);
    @(posedge clk);
    core.raw <= 1'b0;
    wl(3, 1'b0, n);
    wl(2, 1'b1, n);
    chk("dead time b", eb, n);
    $display("test dead time done");
  endtask

  task automatic t_delay(input logic [10:0] d);
    int n;
    load(12'h002, 12'h002, d, 12'h040, 12'h020);
    @(posedge clk);
    core.raw <= 1'b1;
    wl(2, 1'b0, n);
    wl(0, 1'b0, n);
    chk("pair delay", d + 1, n);
    @(posedge clk);
    core.raw <= 1'b0;
    wl(0, 1'b1, n);
    $display("test delay done");
  endtask

  task automatic t_meas();
    int n;
    logic [31:0] r, c;
    wr(`HBP_IDX_MMODE, 8'h80);
    for (int s = 0; s < 2; s++) begin
      wr(`HBP_IDX_MCTL, 8'h10 | 8'(s));
      wr(`HBP_IDX_MCTL, 8'h18 | 8'(s));
      rd(`HBP_IDX_MCAP_LO, r);
      chk("capture cleared", 1, r[7:0] <= 4);
      ww(mflag, n);
      wr(`HBP_IDX_MSTAT, 8'h01);
      ww(mflag, n);
      rd(`HBP_IDX_MCAP_LO, r);
      chk("interval count", 1, r[7:0] + 2 >= (16 << s) && r[7:0] <= (16 << s) + 1);
    end
    wr(`HBP_IDX_MCTL, 8'h10);
    rd(`HBP_IDX_MCNT_LO, c);
    repeat (40) @(posedge clk);
    rd(`HBP_IDX_MCNT_LO, r);
    chk("frozen count", c[7:0], r[7:0]);
    $display("test measure done");
  endtask

  task automatic t_phase();
    int n;
    logic [31:0] r;
    wr(`HBP_IDX_PHWIN, 8'h01);
    wr(`HBP_IDX_MMODE, 8'h00);
    wr(`HBP_IDX_MSTAT, 8'h01);
    wr(`HBP_IDX_MCTL, 8'h18);
    @(posedge clk);
    ph <= 1'b1;
    ww(pwin, n);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (pwin === 1'b1 && n < 50);
    chk("phase window", 2, n);
    rd(`HBP_IDX_MSTAT, r);
    chk("capture on rise", 1, r[0]);
    wr(`HBP_IDX_MSTAT, 8'h01);
    @(posedge clk);
    ph <= 1'b0;
    repeat (10) @(posedge clk);
    rd(`HBP_IDX_MSTAT, r);
    chk("no capture on fall", 0, r[0]);
    wr(`HBP_IDX_MCTL, 8'h00);
    $display("test phase done");
  endtask

  task automatic t_adj();
    int n;
    wr(10, 8'h10);
    wr(12, 8'h20);
    @(posedge clk);
    core.period <= 12'h100;
    @(posedge clk);
    areq <= 1'b1;
    acode <= 2'h3;
    core.boundary <= 1'b1;
    @(posedge clk);
    core.boundary <= 1'b0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (padj === 12'h100 && n < 50);
    chk("stepped period", 12'h0E0, padj);
    @(posedge clk);
    areq <= 1'b0;
    $display("test adjust done");
  endtask

  task automatic t_jit();
    int n;
    logic [31:0] r;
    wr(`HBP_IDX_JPRE1, 8'hFE);
    for (int p = 0; p < 4; p++) begin
      wr(`HBP_IDX_JCTL, 8'h08 | 8'(p));
      ww(jwrap, n);
      ww(jwrap, n);
      chk("jitter interval", 256 << p, n);
      rd(`HBP_IDX_JCTL, r);
      chk("section code", 8'h08 | 8'(p), r[7:0]);
      wr(`HBP_IDX_JCTL, 8'(p));
      n = 0;
      repeat (1200) begin @(posedge clk); #1; n += (jwrap !== 1'b0); end
      chk("stopped timer", 0, n);
    end
    $display("test jitter done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_dead(12'h002, 12'h003, 12'h040, 12'h020, 3, 4);
    t_dead(12'h103, 12'h001, 12'h400, 12'h200, 260, 2);
    t_dead(12'h005, 12'h00C, 12'h00A, 12'h002, 3, 9);
    t_delay(11'h000);
    t_delay(11'h105);
    t_meas();
    t_phase();
    t_adj();
    t_jit();
    chk("no shoot-through", 0, fault);
    results();
  end
endmodule
